// ---- ssp_byte_model.sv ----
// byte engine stand-in: shifts one byte msb first into the register block
// assumes one clock shared with the register block; go is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module ssp_byte_model (
  input wire logic aclk,
  input wire logic go,
  input wire logic slow,
  input wire logic [7:0] byte_val,
  output logic shift_en,
  output logic shift_in,
  output logic byte_done
);
  initial begin
    shift_en = 1'b0;
    shift_in = 1'b0;
    byte_done = 1'b0;
  end
  // one strobe a bit; when slow an idle cycle with the line inverted follows each bit
  always @(posedge aclk) begin
    if (go) begin
      for (int i = 7; i >= 0; i--) begin
        shift_en <= 1'b1;
        shift_in <= byte_val[i];
        @(posedge aclk);
        if (slow) begin
          shift_en <= 1'b0;
          shift_in <= ~byte_val[i];
          @(posedge aclk);
        end
      end
      shift_en <= 1'b0;
      shift_in <= ~byte_val[0];
      byte_done <= 1'b1;
      @(posedge aclk);
      byte_done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- ssp_pkg.sv ----
// register map, field positions and reset values of the serial port register block
// assumes an axi4-lite master with 32-bit data in the same clock domain
package ssp_pkg;
  // byte offsets of the register words
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0c;
  localparam logic [7:0] ADDR_ADDRESS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_LINK = 8'h1c;
  // status register field positions
  localparam int STAT_SLEW = 7;
  localparam int STAT_SMBUS = 6;
  localparam int STAT_DATA_ADDR = 5;
  localparam int STAT_STOP = 4;
  localparam int STAT_START = 3;
  localparam int STAT_READ_WRITE = 2;
  localparam int STAT_UPD_ADDR = 1;
  localparam int STAT_BUF_FULL = 0;
  // mask of software-writable status bits
  localparam logic [7:0] STAT_WR_MASK = 8'hc0;
  // interrupt status bit positions
  localparam int IRQ_RX_BYTE = 0;
  localparam int IRQ_ADDR_MATCH = 1;
  localparam int IRQ_WIDTH = 2;
  // reset value and baud reload mask
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] BAUD_MASK = 7'h7f;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- ssp_regs.sv ----
// serial port register block: controls, status, data buffer, shift register, address
// assumes the byte engine supplies shift strobes and status events on aclk
`timescale 1ns/100ps
`default_nettype none

module ssp_regs (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // byte engine side
  input wire logic master_mode,
  input wire logic shift_en,
  input wire logic shift_in,
  input wire logic byte_done,
  input wire logic addr_phase,
  input wire logic [5:0] bus_status,
  output logic shift_out,
  output logic addr_match,
  output logic [6:0] baud_reload,
  output logic slew_limit_en,
  output logic smbus_inputs_en,
  output logic [7:0] ctrl_one,
  output logic [7:0] ctrl_two,
  output logic irq
);
  import ssp_pkg::*;

  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic [1:0] stat_hi;
    logic [5:0] stat_lo;
    logic [7:0] data_buf;
    logic [7:0] shift_reg;
    logic [7:0] own_addr;
    logic [IRQ_WIDTH-1:0] irq_stat;
    logic [IRQ_WIDTH-1:0] irq_mask;
    logic match;
  } ssp_state_type;

  ssp_state_type st_ff;
  ssp_state_type nxt_st;
  logic do_write;
  logic [7:0] wb;
  logic [7:0] status_val;
  logic [IRQ_WIDTH-1:0] irq_evt;
  logic [7:0] shifted;

  // ----------------------------------------------------------------
  // combinational next state
  // ----------------------------------------------------------------
  assign status_val = {st_ff.stat_hi, st_ff.stat_lo};
  assign shifted = {st_ff.shift_reg[6:0], shift_in};

  // write lane 0 carries the 8-bit registers
  always_comb begin
    nxt_st = st_ff;
    do_write = 1'b0;
    wb = st_ff.w_data[7:0];
    irq_evt = '0;
    if (s_axi_awvalid && !st_ff.aw_got && !st_ff.bvalid) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_ff.w_got && !st_ff.bvalid) begin
      nxt_st.w_got = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    // engine: shift and byte completion
    if (shift_en) begin
      nxt_st.shift_reg = shifted;
    end
    if (byte_done) begin
      nxt_st.data_buf = st_ff.shift_reg;
      irq_evt[IRQ_RX_BYTE] = 1'b1;
      // slave address phase compares against own address
      if (addr_phase && !master_mode && st_ff.shift_reg[7:1] == st_ff.own_addr[7:1]) begin
        irq_evt[IRQ_ADDR_MATCH] = 1'b1;
      end
    end
    if (byte_done && addr_phase && !master_mode) begin
      nxt_st.match = (st_ff.shift_reg[7:1] == st_ff.own_addr[7:1]);
    end
    nxt_st.stat_lo = bus_status;
    // register write once both address and data are held
    if (st_ff.aw_got && st_ff.w_got) begin
      do_write = st_ff.w_strb[0];
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
      case (st_ff.aw_addr)
        ADDR_CTRL_ONE: if (do_write) nxt_st.ctrl_one = wb;
        ADDR_CTRL_TWO: if (do_write) nxt_st.ctrl_two = wb;
        ADDR_STATUS: if (do_write) nxt_st.stat_hi = wb[7:6];
        ADDR_DATA: if (do_write) begin
          nxt_st.data_buf = wb;
          nxt_st.shift_reg = wb;
        end
        ADDR_ADDRESS: if (do_write) nxt_st.own_addr = wb;
        ADDR_IRQ_STAT: if (do_write) begin
          nxt_st.irq_stat = st_ff.irq_stat & ~wb[IRQ_WIDTH-1:0];
        end
        ADDR_IRQ_MASK: if (do_write) nxt_st.irq_mask = wb[IRQ_WIDTH-1:0];
        ADDR_LINK: ;
        default: nxt_st.bresp = RESP_SLVERR;
      endcase
    end
    // events win over a simultaneous clear
    nxt_st.irq_stat = nxt_st.irq_stat | irq_evt;
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // read channel, one outstanding read; the shift register has no address
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_ff.rvalid) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = RESP_OKAY;
      nxt_st.rdata = '0;
      case (s_axi_araddr)
        ADDR_CTRL_ONE: nxt_st.rdata[7:0] = st_ff.ctrl_one;
        ADDR_CTRL_TWO: nxt_st.rdata[7:0] = st_ff.ctrl_two;
        ADDR_STATUS: nxt_st.rdata[7:0] = status_val;
        ADDR_DATA: nxt_st.rdata[7:0] = st_ff.data_buf;
        ADDR_ADDRESS: nxt_st.rdata[7:0] = st_ff.own_addr;
        ADDR_IRQ_STAT: nxt_st.rdata[IRQ_WIDTH-1:0] = st_ff.irq_stat;
        ADDR_IRQ_MASK: nxt_st.rdata[IRQ_WIDTH-1:0] = st_ff.irq_mask;
        ADDR_LINK: nxt_st.rdata[0] = st_ff.match;
        default: nxt_st.rresp = RESP_SLVERR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign shift_out = st_ff.shift_reg[7];
  assign addr_match = st_ff.match;
  assign baud_reload = master_mode ? (st_ff.own_addr[6:0] & BAUD_MASK) : 7'h00;
  assign slew_limit_en = !st_ff.stat_hi[STAT_SLEW-6];
  assign smbus_inputs_en = st_ff.stat_hi[STAT_SMBUS-6];
  assign ctrl_one = st_ff.ctrl_one;
  assign ctrl_two = st_ff.ctrl_two;
  assign irq = |(st_ff.irq_stat & st_ff.irq_mask);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_rx_copy;
    @(posedge aclk) disable iff (!aresetn)
      byte_done && !(st_ff.aw_got && st_ff.w_got && st_ff.aw_addr == ADDR_DATA)
      |=> st_ff.data_buf == $past(st_ff.shift_reg) && st_ff.irq_stat[IRQ_RX_BYTE];
  endproperty
  a_rx_copy: assert property (p_rx_copy) else $error("received byte not moved");

  property p_tx_load;
    @(posedge aclk) disable iff (!aresetn)
      st_ff.aw_got && st_ff.w_got && st_ff.aw_addr == ADDR_DATA && st_ff.w_strb[0]
      |=> st_ff.shift_reg == $past(st_ff.w_data[7:0])
      && st_ff.data_buf == $past(st_ff.w_data[7:0]);
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("buffer write not in shifter");

  property p_stat_lo;
    @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> status_val[5:0] == $past(bus_status);
  endproperty
  a_stat_lo: assert property (p_stat_lo) else $error("low status bits not hardware");

  property p_stat_hi;
    @(posedge aclk) disable iff (!aresetn)
      st_ff.aw_got && st_ff.w_got && st_ff.aw_addr == ADDR_STATUS && st_ff.w_strb[0]
      |=> status_val[7:6] == $past(st_ff.w_data[7:6]);
  endproperty
  a_stat_hi: assert property (p_stat_hi) else $error("high status bits not written");

  property p_ctrl;
    @(posedge aclk) disable iff (!aresetn)
      st_ff.aw_got && st_ff.w_got && st_ff.aw_addr == ADDR_CTRL_TWO && st_ff.w_strb[0]
      |=> ctrl_two == $past(st_ff.w_data[7:0]) ##1 ctrl_two == $past(ctrl_two);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control write lost");

  property p_baud;
    @(posedge aclk) disable iff (!aresetn)
      master_mode |-> baud_reload == st_ff.own_addr[6:0];
  endproperty
  a_baud: assert property (p_baud) else $error("baud reload wrong");

  property p_slew;
    @(posedge aclk) disable iff (!aresetn)
      slew_limit_en != status_val[STAT_SLEW] && smbus_inputs_en == status_val[STAT_SMBUS];
  endproperty
  a_slew: assert property (p_slew) else $error("pad controls disagree");

  property p_match;
    @(posedge aclk) disable iff (!aresetn)
      byte_done && addr_phase && !master_mode
      |=> addr_match == ($past(st_ff.shift_reg[7:1]) == $past(st_ff.own_addr[7:1]));
  endproperty
  a_match: assert property (p_match) else $error("own address not matched");

  property p_reset;
    @(posedge aclk) !aresetn |=> status_val == RST_BYTE;
  endproperty
  a_reset: assert property (p_reset) else $error("status not zero after reset");

  // a received byte always leaves its flag set, even against a clear
  property p_irq_rx_set;
    @(posedge aclk) disable iff (!aresetn)
      byte_done |=> st_ff.irq_stat[IRQ_RX_BYTE];
  endproperty
  a_irq_rx_set: assert property (p_irq_rx_set) else $error("rx flag lost to a clear");

  property p_ctrl_one;
    @(posedge aclk) disable iff (!aresetn)
      st_ff.aw_got && st_ff.w_got && st_ff.aw_addr == ADDR_CTRL_ONE && st_ff.w_strb[0]
      |=> ctrl_one == $past(st_ff.w_data[7:0]);
  endproperty
  a_ctrl_one: assert property (p_ctrl_one) else $error("control one write lost");

  // a write with lane 0 off changes no register
  property p_no_strobe;
    @(posedge aclk) disable iff (!aresetn)
      st_ff.aw_got && st_ff.w_got && !st_ff.w_strb[0]
      |=> $stable(ctrl_one) && $stable(ctrl_two) && $stable(status_val[7:6]);
  endproperty
  a_no_strobe: assert property (p_no_strobe) else $error("write without strobe landed");

  property p_baud_slave;
    @(posedge aclk) disable iff (!aresetn)
      !master_mode |-> baud_reload == 7'h00;
  endproperty
  a_baud_slave: assert property (p_baud_slave) else $error("baud reload in slave mode");

  // the high status bits move only on a software write
  property p_stat_hi_hold;
    @(posedge aclk) disable iff (!aresetn)
      !(st_ff.aw_got && st_ff.w_got && st_ff.aw_addr == ADDR_STATUS && st_ff.w_strb[0])
      |=> $stable(status_val[7:6]);
  endproperty
  a_stat_hi_hold: assert property (p_stat_hi_hold) else $error("high status bits moved");

  // no address outside the map reaches any register, the shifter included
  property p_rd_unmapped;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready
      && (s_axi_araddr > ADDR_LINK || s_axi_araddr[1:0] != 2'h0)
      |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read answered");

  property p_wr_unmapped;
    @(posedge aclk) disable iff (!aresetn)
      st_ff.aw_got && st_ff.w_got
      && (st_ff.aw_addr > ADDR_LINK || st_ff.aw_addr[1:0] != 2'h0)
      |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
  endproperty
  a_wr_unmapped: assert property (p_wr_unmapped) else $error("unmapped write accepted");
endmodule
`default_nettype wire

// ---- ssp_regs_tb.sv ----
// self-checking bench of the serial port register block over axi4-lite
// assumes ssp_pkg, ssp_regs and ssp_byte_model are compiled first
`timescale 1ns/100ps
`default_nettype none
module ssp_regs_tb;
  import ssp_pkg::*;
  logic aclk, aresetn, awv, wv, bre, arv, rre, mm, go, slow, ap, se, si, bd;
  logic awrdy, wrdy, bval, arrdy, rval, so, am, sle, sme, irq;
  logic [1:0] brsp, rrsp, rsp, wr_rsp;
  logic [3:0] ws;
  logic [7:0] awa, ara, bv, v, own, c1, c2;
  logic [5:0] bs;
  logic [6:0] baud;
  logic [31:0] wd, rdat, got;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  ssp_regs uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awrdy), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(brsp), .s_axi_bvalid(bval), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arrdy), .s_axi_rdata(rdat),
    .s_axi_rresp(rrsp), .s_axi_rvalid(rval), .s_axi_rready(rre), .master_mode(mm),
    .shift_en(se), .shift_in(si), .byte_done(bd), .addr_phase(ap), .bus_status(bs),
    .shift_out(so), .addr_match(am), .baud_reload(baud), .slew_limit_en(sle),
    .smbus_inputs_en(sme), .ctrl_one(c1), .ctrl_two(c2), .irq(irq));
  ssp_byte_model bm (.aclk(aclk), .go(go), .slow(slow), .byte_val(bv), .shift_en(se),
    .shift_in(si), .byte_done(bd));
  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      summarize();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write: offer address and data together, release each when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit ad, dd;
    ad = 0;
    dd = 0;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (!ad && awrdy === 1'b1) begin ad = 1; awv <= 1'b0; end
      if (!dd && wrdy === 1'b1) begin dd = 1; wv <= 1'b0; end
    end
    do @(posedge aclk); while (bval !== 1'b1);
    wr_rsp = brsp;
    bre <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge aclk); while (arrdy !== 1'b1);
    arv <= 1'b0;
    do @(posedge aclk); while (rval !== 1'b1);
    d = rdat;
    r = rrsp;
    rre <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    axi_rd(a, got, rsp);
    chk(nm, e, got);
  endtask
  task automatic send_byte(input logic [7:0] b, input logic addr);
    bv <= b;
    ap <= addr;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    do @(posedge aclk); while (bd !== 1'b1);
    repeat (2) @(posedge aclk);
  endtask
  function automatic logic [31:0] stat_exp(input logic [7:0] w, input logic [5:0] b);
    return {24'h0, w[7:6], b};
  endfunction
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {aresetn, awv, wv, bre, arv, rre, mm, go, slow, ap} = '0;
    {awa, ara, bv, bs, wd} = '0;
    ws = 4'hf;
    got = $urandom(32'h99dc7da0);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("status", ADDR_STATUS, 32'h0);
    rd_chk("ctrl_two", ADDR_CTRL_TWO, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      axi_wr(ADDR_CTRL_ONE + 8'(4 * (i % 2)), {24'hffffff, v});
      rd_chk("ctrl", ADDR_CTRL_ONE + 8'(4 * (i % 2)), {24'h0, v});
      chk("write resp", RESP_OKAY, wr_rsp);
      chk("read resp", RESP_OKAY, rsp);
      chk("ctrl port", v, (i % 2) ? c2 : c1);
      bs <= 6'($urandom);
      axi_wr(ADDR_STATUS, {24'h0, v ^ 8'h3f});
      rd_chk("status", ADDR_STATUS, stat_exp(v, bs));
      chk("slew_limit_en", {31'h0, !v[7]}, sle);
      chk("smbus_inputs_en", v[6], sme);
    end
    $display("test control and status done");
    axi_wr(ADDR_CTRL_ONE, 32'ha5);
    ws <= 4'h0;
    axi_wr(ADDR_CTRL_ONE, 32'h5a);
    chk("no strobe resp", RESP_OKAY, wr_rsp);
    chk("no strobe ctrl", 32'ha5, c1);
    ws <= 4'hf;
    axi_wr(8'h24, 32'h1);
    chk("unmapped write resp", RESP_SLVERR, wr_rsp);
    bs <= 6'h00;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("status after reset", ADDR_STATUS, 32'h0);
    chk("ctrl_one after reset", 32'h0, c1);
    chk("slew after reset", 32'h1, sle);
    $display("test strobe, response and reset done");
    own = 8'($urandom);
    axi_wr(ADDR_ADDRESS, {24'h0, own});
    mm <= 1'b1;
    @(posedge aclk);
    chk("baud_reload", own[6:0], baud);
    v = 8'($urandom);
    axi_wr(ADDR_DATA, {24'h0, v});
    chk("shift_out", v[7], so);
    rd_chk("data", ADDR_DATA, {24'h0, v});
    $display("test address and transmit done");
    axi_wr(ADDR_IRQ_MASK, 32'h0);
    mm <= 1'b0;
    slow <= 1'b1;
    v = ~v;
    send_byte(v, 1'b0);
    rd_chk("rx data", ADDR_DATA, {24'h0, v});
    rd_chk("irq status", ADDR_IRQ_STAT, 32'h1);
    chk("irq masked", 1'b0, irq);
    axi_wr(ADDR_IRQ_MASK, 32'h1);
    @(posedge aclk);
    chk("irq", 1'b1, irq);
    axi_wr(ADDR_IRQ_STAT, 32'h1);
    @(posedge aclk);
    chk("irq cleared", 1'b0, irq);
    $display("test receive done");
    slow <= 1'b0;
    send_byte({own[7:1], 1'b1}, 1'b1);
    chk("addr_match", 1'b1, am);
    rd_chk("link", ADDR_LINK, 32'h1);
    rd_chk("irq status match", ADDR_IRQ_STAT, 32'h3);
    send_byte({~own[7:1], 1'b0}, 1'b1);
    chk("addr_mismatch", 1'b0, am);
    axi_rd(8'h20, got, rsp);
    chk("unmapped resp", RESP_SLVERR, rsp);
    chk("unmapped data", 32'h0, got);
    $display("test slave address done");
    summarize();
  end
endmodule
`default_nettype wire
